// ==== design/cair_queue.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cair_params.svh"
module cair_queue (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic [`CAIR_BYTE_W-1:0] push_byte_i,
  input wire logic [`CAIR_CNT_W-1:0] pop_n_i,
  output logic [`CAIR_CNT_W-1:0] count_o,
  output logic [`CAIR_BYTE_W-1:0] head0_o,
  output logic [`CAIR_BYTE_W-1:0] head1_o,
  output logic [`CAIR_BYTE_W-1:0] head2_o
);
  logic [`CAIR_BYTE_W-1:0] mem_r [`CAIR_QUEUE_DEPTH];
  logic [`CAIR_PTR_W-1:0] rd_r, wr_r;
  logic [`CAIR_CNT_W-1:0] cnt_r;
  logic [`CAIR_CNT_W-1:0] pop_eff;
  logic push_ok;
  // Pops never exceed what is held; pushes are dropped only when full with no pop in that cycle
  assign pop_eff = (pop_n_i > cnt_r) ? cnt_r : pop_n_i;
  assign push_ok = push_i && (cnt_r - pop_eff < `CAIR_CNT_W'(`CAIR_QUEUE_DEPTH));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push_ok) begin
        mem_r[wr_r] <= push_byte_i;
        wr_r <= wr_r + `CAIR_PTR_ONE;
      end
      rd_r <= rd_r + pop_eff[`CAIR_PTR_W-1:0];
      cnt_r <= cnt_r - pop_eff + (push_ok ? `CAIR_CNT_ONE : '0);
    end
  end
  always_ff @(posedge clk_i) begin
    head0_o <= mem_r[rd_r + pop_eff[`CAIR_PTR_W-1:0]];
    head1_o <= mem_r[rd_r + pop_eff[`CAIR_PTR_W-1:0] + `CAIR_PTR_ONE];
    head2_o <= mem_r[rd_r + pop_eff[`CAIR_PTR_W-1:0] + `CAIR_PTR_TWO];
  end
  assign count_o = cnt_r;
endmodule // cair_queue
`default_nettype wire

// ==== design/cair_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cair_params.svh"
// How it works
// - Two 8-bit accumulators hold operands, results
// - Long register joins both accumulators, 16 bits
// - Effective address: pointer plus constant or accumulator
// - Pointers load and store as plain data
// - No memory-mapped access; instruction ports only
// - 16-bit paths plus 20-bit extended register
// - Queue keeps three code bytes ready
// - Instruction length consumed up to the bytes held, no padding
// - Words to memory: high byte lower address
module cair_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cair_pkg::cair_wr_s wr_i,
  input wire cair_pkg::cair_sel_e rd_sel_i,
  input wire logic ext_we_i,
  input wire logic [`CAIR_EXT_W-1:0] ext_data_i,
  input wire cair_pkg::cair_ea_s ea_i,
  input wire logic st_req_i,
  input wire logic [`CAIR_WORD_W-1:0] st_addr_i,
  input wire logic fetch_vld_i,
  input wire logic [`CAIR_BYTE_W-1:0] fetch_byte_i,
  input wire logic insn_start_i,
  input wire logic [`CAIR_CNT_W-1:0] insn_len_i,
  output logic [`CAIR_WORD_W-1:0] rd_data_o,
  output logic [`CAIR_EXT_W-1:0] ext_o,
  output logic [`CAIR_WORD_W-1:0] ea_o,
  output logic ea_vld_o,
  output logic [`CAIR_BYTE_W-1:0] mem_b0_o,
  output logic [`CAIR_BYTE_W-1:0] mem_b1_o,
  output logic [`CAIR_WORD_W-1:0] mem_a0_o,
  output logic [`CAIR_WORD_W-1:0] mem_a1_o,
  output logic insn_ready_o,
  output logic [`CAIR_BYTE_W-1:0] code0_o,
  output logic [`CAIR_BYTE_W-1:0] code1_o,
  output logic [`CAIR_BYTE_W-1:0] code2_o
);
  import cair_pkg::*;
  cair_state_s st_r, st_nxt;
  logic [`CAIR_WORD_W-1:0] long_val, base, ofs, st_val;
  logic [`CAIR_CNT_W-1:0] q_cnt, pop_n, pop_clip;
  // Registers live only behind these instruction ports
  assign long_val = {st_r.hi, st_r.lo};
  always_comb begin
    st_nxt = st_r;
    base = ea_i.use_second ? st_r.p2 : st_r.p1;
    unique case (ea_i.ofs_sel)
      CAIR_OFS_CONST: ofs = ea_i.konst;
      CAIR_OFS_HI: ofs = {`CAIR_BYTE_W'(0), st_r.hi};
      CAIR_OFS_LO: ofs = {`CAIR_BYTE_W'(0), st_r.lo};
      CAIR_OFS_LONG: ofs = long_val;
    endcase
    st_nxt.ea = base + ofs;
    st_nxt.ea_vld = ea_i.req;
    if (wr_i.we) begin
      unique case (wr_i.sel)
        CAIR_SEL_HI: st_nxt.hi = wr_i.data[`CAIR_BYTE_W-1:0];
        CAIR_SEL_LO: st_nxt.lo = wr_i.data[`CAIR_BYTE_W-1:0];
        CAIR_SEL_LONG: begin
          st_nxt.hi = wr_i.data[`CAIR_WORD_W-1:`CAIR_HI_LSB];
          st_nxt.lo = wr_i.data[`CAIR_HI_LSB-1:0];
        end
        CAIR_SEL_P1: st_nxt.p1 = wr_i.data;
        CAIR_SEL_P2: st_nxt.p2 = wr_i.data;
        default: ;
      endcase
    end
    if (ext_we_i) begin
      st_nxt.ext = ext_data_i;
    end
    unique case (rd_sel_i)
      CAIR_SEL_HI: st_nxt.rd = {`CAIR_BYTE_W'(0), st_r.hi};
      CAIR_SEL_LO: st_nxt.rd = {`CAIR_BYTE_W'(0), st_r.lo};
      CAIR_SEL_LONG: st_nxt.rd = long_val;
      CAIR_SEL_P1: st_nxt.rd = st_r.p1;
      CAIR_SEL_P2: st_nxt.rd = st_r.p2;
      default: st_nxt.rd = '0;
    endcase
    unique case (rd_sel_i)
      CAIR_SEL_P1: st_val = st_r.p1;
      CAIR_SEL_P2: st_val = st_r.p2;
      default: st_val = long_val;
    endcase
    if (st_req_i) begin
      st_nxt.mem_b0 = st_val[`CAIR_WORD_W-1:`CAIR_HI_LSB];
      st_nxt.mem_b1 = st_val[`CAIR_HI_LSB-1:0];
      st_nxt.mem_a0 = st_addr_i;
      st_nxt.mem_a1 = st_addr_i + `CAIR_ADDR_ONE;
    end
    // Clipped pop, else an over-long length wraps the count upward
    st_nxt.rdy = (q_cnt - pop_clip) >= `CAIR_CNT_W'(`CAIR_QUEUE_MIN);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // Consume the instruction length, clipped to the bytes held, odd or single byte
  assign pop_n = insn_start_i ? insn_len_i : '0;
  assign pop_clip = (pop_n > q_cnt) ? q_cnt : pop_n;
  cair_queue u_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(fetch_vld_i),
    .push_byte_i(fetch_byte_i),
    .pop_n_i(pop_n),
    .count_o(q_cnt),
    .head0_o(code0_o),
    .head1_o(code1_o),
    .head2_o(code2_o)
  );
  assign rd_data_o = st_r.rd;
  assign ext_o = st_r.ext;
  assign ea_o = st_r.ea;
  assign ea_vld_o = st_r.ea_vld;
  assign mem_b0_o = st_r.mem_b0;
  assign mem_b1_o = st_r.mem_b1;
  assign mem_a0_o = st_r.mem_a0;
  assign mem_a1_o = st_r.mem_a1;
  assign insn_ready_o = st_r.rdy;

  property p_long_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_LONG) |=> (long_val == $past(wr_i.data));
  endproperty
  a_long_write: assert property (p_long_write) else $error("long write lost");
  property p_hi_hold;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_LO) |=> (st_r.hi == $past(st_r.hi));
  endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high byte disturbed");
  property p_long_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd_sel_i == CAIR_SEL_LONG) |=> (rd_data_o == $past(long_val));
  endproperty
  a_long_read: assert property (p_long_read) else $error("long read wrong");
  property p_ea_sum;
    @(posedge clk_i) disable iff (rst_i)
      (ea_i.req && !ea_i.use_second && ea_i.ofs_sel == CAIR_OFS_CONST)
        |=> ea_vld_o && (ea_o == $past(st_r.p1) + $past(ea_i.konst));
  endproperty
  a_ea_sum: assert property (p_ea_sum) else $error("address sum wrong");
  property p_ptr_store;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_P2) ##1 (!wr_i.we && rd_sel_i == CAIR_SEL_P2)
        |=> (rd_data_o == $past(wr_i.data, 2));
  endproperty
  a_ptr_store: assert property (p_ptr_store) else $error("pointer data lost");
  property p_ext_load;
    @(posedge clk_i) disable iff (rst_i) ext_we_i |=> (ext_o == $past(ext_data_i));
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("wide register lost");
  property p_ready;
    @(posedge clk_i) disable iff (rst_i)
      insn_ready_o |-> (q_cnt >= `CAIR_CNT_W'(`CAIR_QUEUE_MIN));
  endproperty
  a_ready: assert property (p_ready) else $error("ready without three bytes");
  property p_pop;
    @(posedge clk_i) disable iff (rst_i)
      (insn_start_i && !fetch_vld_i && q_cnt >= insn_len_i)
        |=> (q_cnt == $past(q_cnt) - $past(insn_len_i));
  endproperty
  a_pop: assert property (p_pop) else $error("length not consumed");
  property p_big_end;
    @(posedge clk_i) disable iff (rst_i)
      st_req_i |=> (mem_b0_o == $past(st_val[`CAIR_WORD_W-1:`CAIR_HI_LSB]))
        && (mem_a1_o == mem_a0_o + `CAIR_ADDR_ONE);
  endproperty
  a_big_end: assert property (p_big_end) else $error("byte order wrong");
  property p_lo_hold;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_HI) |=> (st_r.lo == $past(st_r.lo));
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low byte disturbed");
  property p_lo_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_LO) |=> (st_r.lo == $past(wr_i.data[`CAIR_BYTE_W-1:0]));
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low byte write lost");
  property p_long_split;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_LONG)
        |=> (st_r.hi == $past(wr_i.data[`CAIR_WORD_W-1:`CAIR_HI_LSB]))
          && (st_r.lo == $past(wr_i.data[`CAIR_HI_LSB-1:0]));
  endproperty
  a_long_split: assert property (p_long_split) else $error("long halves swapped");
  property p_ea_long;
    @(posedge clk_i) disable iff (rst_i)
      (ea_i.req && ea_i.use_second && ea_i.ofs_sel == CAIR_OFS_LONG)
        |=> ea_vld_o && (ea_o == $past(st_r.p2) + $past(long_val));
  endproperty
  a_ea_long: assert property (p_ea_long) else $error("long offset sum wrong");
  property p_ea_byte;
    @(posedge clk_i) disable iff (rst_i)
      (ea_i.req && !ea_i.use_second && ea_i.ofs_sel == CAIR_OFS_LO)
        |=> ea_vld_o && (ea_o == $past(st_r.p1) + {`CAIR_BYTE_W'(0), $past(st_r.lo)});
  endproperty
  a_ea_byte: assert property (p_ea_byte) else $error("byte offset sum wrong");
  property p_ea_pulse;
    @(posedge clk_i) disable iff (rst_i) !ea_i.req |=> !ea_vld_o;
  endproperty
  a_ea_pulse: assert property (p_ea_pulse) else $error("address valid without request");
  property p_p1_load;
    @(posedge clk_i) disable iff (rst_i)
      (wr_i.we && wr_i.sel == CAIR_SEL_P1) |=> (st_r.p1 == $past(wr_i.data));
  endproperty
  a_p1_load: assert property (p_p1_load) else $error("first pointer load lost");
  property p_ext_hold;
    @(posedge clk_i) disable iff (rst_i) !ext_we_i |=> (ext_o == $past(ext_o));
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("wide register drifted");
  property p_ready_drop;
    @(posedge clk_i) disable iff (rst_i)
      (insn_start_i && insn_len_i >= q_cnt) |=> !insn_ready_o;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready after queue drained");
  property p_store_low;
    @(posedge clk_i) disable iff (rst_i)
      st_req_i |=> (mem_b1_o == $past(st_val[`CAIR_HI_LSB-1:0]))
        && (mem_a0_o == $past(st_addr_i));
  endproperty
  a_store_low: assert property (p_store_low) else $error("low byte address wrong");
  property p_store_hold;
    @(posedge clk_i) disable iff (rst_i)
      !st_req_i |=> $stable(mem_b0_o) && $stable(mem_b1_o) && $stable(mem_a0_o);
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store staging drifted");
endmodule // cair_regs
`default_nettype wire

// ==== shared/cair_params.svh ====
`ifndef CAIR_PARAMS_SVH
`define CAIR_PARAMS_SVH
`define CAIR_BYTE_W 8
`define CAIR_WORD_W 16
`define CAIR_EXT_W 20
`define CAIR_QUEUE_DEPTH 4
`define CAIR_QUEUE_MIN 3
`define CAIR_CNT_W 3
`define CAIR_PTR_W 2
`define CAIR_RST_BYTE 8'h00
`define CAIR_RST_WORD 16'h0000
`define CAIR_RST_EXT 20'h00000
`define CAIR_HI_LSB 8
`define CAIR_CNT_ONE 3'h1
`define CAIR_PTR_ONE 2'h1
`define CAIR_PTR_TWO 2'h2
`define CAIR_ADDR_ONE 16'h0001
`endif

// ==== shared/cair_pkg.sv ====
`include "cair_params.svh"
package cair_pkg;
  typedef enum logic [2:0] {
    CAIR_SEL_HI = 3'h0,
    CAIR_SEL_LO = 3'h1,
    CAIR_SEL_LONG = 3'h2,
    CAIR_SEL_P1 = 3'h3,
    CAIR_SEL_P2 = 3'h4
  } cair_sel_e;
  typedef enum logic [1:0] {
    CAIR_OFS_CONST = 2'h0,
    CAIR_OFS_HI = 2'h1,
    CAIR_OFS_LO = 2'h2,
    CAIR_OFS_LONG = 2'h3
  } cair_ofs_e;
  typedef struct packed {
    logic we;
    cair_sel_e sel;
    logic [`CAIR_WORD_W-1:0] data;
  } cair_wr_s;
  typedef struct packed {
    logic req;
    logic use_second;
    cair_ofs_e ofs_sel;
    logic [`CAIR_WORD_W-1:0] konst;
  } cair_ea_s;
  typedef struct packed {
    logic [`CAIR_BYTE_W-1:0] hi;
    logic [`CAIR_BYTE_W-1:0] lo;
    logic [`CAIR_WORD_W-1:0] p1;
    logic [`CAIR_WORD_W-1:0] p2;
    logic [`CAIR_EXT_W-1:0] ext;
    logic [`CAIR_WORD_W-1:0] ea;
    logic ea_vld;
    logic [`CAIR_BYTE_W-1:0] mem_b0;
    logic [`CAIR_BYTE_W-1:0] mem_b1;
    logic [`CAIR_WORD_W-1:0] mem_a1;
    logic [`CAIR_WORD_W-1:0] mem_a0;
    logic [`CAIR_WORD_W-1:0] rd;
    logic rdy;
  } cair_state_s;
endpackage

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cair_params.svh"
module tb_top;
  import cair_pkg::*;
  logic clk_i, rst_i, ext_we_i, st_req_i, fetch_vld_i, insn_start_i, ea_vld_o, insn_ready_o;
  cair_wr_s wr_i;
  cair_sel_e rd_sel_i;
  cair_ea_s ea_i;
  logic [19:0] ext_data_i, ext_o;
  logic [15:0] st_addr_i, rd_data_o, ea_o, mem_a0_o, mem_a1_o, p1, p2;
  logic [7:0] fetch_byte_i, mem_b0_o, mem_b1_o, code0_o, code1_o, code2_o, hi, lo;
  logic [2:0] insn_len_i;
  logic rd_flag, rd_due;
  logic [15:0] rq[$], eq[$];
  logic [31:0] seed, r, r2;
  logic [7:0] qb[5];
  int n_fail, samples_checked;
  cair_regs dut (.clk_i, .rst_i, .wr_i, .rd_sel_i, .ext_we_i, .ext_data_i, .ea_i, .st_req_i,
    .st_addr_i, .fetch_vld_i, .fetch_byte_i, .insn_start_i, .insn_len_i, .rd_data_o, .ext_o,
    .ea_o, .ea_vld_o, .mem_b0_o, .mem_b1_o, .mem_a0_o, .mem_a1_o, .insn_ready_o, .code0_o,
    .code1_o, .code2_o);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] val(cair_sel_e s);
    case (s)
      CAIR_SEL_HI: return {8'h00, hi};
      CAIR_SEL_LO: return {8'h00, lo};
      CAIR_SEL_P1: return p1;
      CAIR_SEL_P2: return p2;
      default: return {hi, lo};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One cycle of register traffic; expectations use values before the write
  task automatic cyc(input cair_wr_s w, input cair_sel_e s, input logic rd, input cair_ea_s e);
    @(posedge clk_i);
    wr_i <= w;
    rd_sel_i <= s;
    rd_flag <= rd;
    ea_i <= e;
    if (rd) rq.push_back(val(s));
    if (e.req) eq.push_back((e.use_second ? p2 : p1) + (e.ofs_sel == CAIR_OFS_CONST ? e.konst :
      val(cair_sel_e'({1'b0, e.ofs_sel - 2'h1}))));
    if (w.we) begin
      case (w.sel)
        CAIR_SEL_HI: hi = w.data[7:0];
        CAIR_SEL_LO: lo = w.data[7:0];
        CAIR_SEL_P1: p1 = w.data;
        CAIR_SEL_P2: p2 = w.data;
        default: {hi, lo} = w.data;
      endcase
    end
  endtask
  task automatic qchk(input logic rdy, input int i);
    @(negedge clk_i);
    chk("ready", insn_ready_o, rdy);
    chk("code0", code0_o, qb[i]);
    chk("code1", code1_o, qb[i+1]);
    chk("code2", code2_o, qb[i+2]);
  endtask
  task automatic step(input logic f, input logic [7:0] b, input logic s, input logic [2:0] n);
    @(posedge clk_i);
    fetch_vld_i <= f;
    fetch_byte_i <= b;
    insn_start_i <= s;
    insn_len_i <= n;
    @(posedge clk_i);
    fetch_vld_i <= 1'b0;
    insn_start_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  always @(posedge clk_i) rd_due <= rd_flag;
  always @(negedge clk_i) begin
    if (rd_due === 1'b1) chk("rd_data", rd_data_o, rq.pop_front());
    if (ea_vld_o === 1'b1) chk("ea", ea_o, eq.size() ? eq.pop_front() : ~ea_o);
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    results();
  end
  initial begin
    seed = 32'h8BF11058;
    wr_i = '0;
    rd_sel_i = CAIR_SEL_HI;
    ea_i = '0;
    {ext_we_i, ext_data_i, st_req_i, st_addr_i} = '0;
    {fetch_vld_i, fetch_byte_i, insn_start_i, insn_len_i, rd_flag, hi, lo, p1, p2} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 5; k++) cyc('0, cair_sel_e'(k), 1'b1, '0);
    repeat (60) begin
      r = rnd();
      r2 = rnd();
      cyc('{r[0], cair_sel_e'(3'(r[7:1] % 5)), r[31:16]}, cair_sel_e'(3'(r[14:8] % 5)), 1'b1,
        '{r2[31], r2[30], cair_ofs_e'(r2[29:28]), r2[15:0]});
    end
    cyc('0, CAIR_SEL_HI, 1'b0, '0);
    r = rnd();
    @(posedge clk_i);
    ext_we_i <= 1'b1;
    ext_data_i <= r[19:0];
    @(posedge clk_i);
    ext_we_i <= 1'b0;
    @(negedge clk_i);
    chk("ext", ext_o, r[19:0]);
    for (int k = 2; k < 5; k++) begin
      r = (k == 4) ? 32'hFFFF : rnd();
      @(posedge clk_i);
      rd_sel_i <= cair_sel_e'(k);
      st_req_i <= 1'b1;
      st_addr_i <= r[15:0];
      @(posedge clk_i);
      st_req_i <= 1'b0;
      @(negedge clk_i);
      chk("mem_b0", mem_b0_o, val(cair_sel_e'(k)) >> 8);
      chk("mem_b1", mem_b1_o, val(cair_sel_e'(k)) & 16'h00FF);
      chk("mem_a0", mem_a0_o, r[15:0]);
      chk("mem_a1", mem_a1_o, 16'(r[15:0] + 16'h0001));
    end
    foreach (qb[i]) qb[i] = 8'(rnd());
    foreach (qb[i]) step(1'b1, qb[i], 1'b0, 3'h0);
    qchk(1'b1, 0);
    step(1'b0, 8'h00, 1'b1, 3'h1);
    qchk(1'b1, 1);
    step(1'b0, 8'h00, 1'b1, 3'h1);
    @(negedge clk_i);
    chk("ready", insn_ready_o, 1'b0);
    step(1'b1, qb[4], 1'b0, 3'h0);
    qchk(1'b1, 2);
    step(1'b0, 8'h00, 1'b1, 3'h7);
    @(negedge clk_i);
    chk("ready", insn_ready_o, 1'b0);
    chk("rd_left", rq.size(), 0);
    chk("ea_left", eq.size(), 0);
    results();
  end
endmodule // tb_top
`default_nettype wire
